// File: design/sps_pkg.sv
// Constants shared by the serial port pin-sharing block.
// Assumes a single 20 MHz system clock domain.
package sps_pkg;
    // Serial word and fifo geometry
    localparam int WORD_W = 24;
    localparam int FIFO_DEPTH = 8;
    localparam int CNT_W = 5;
    // Pin indices within the six shared port lines (port lines 3..8)
    localparam int PIN_N = 6;
    localparam int PIN_A = 0;
    localparam int PIN_B = 1;
    localparam int PIN_C = 2;
    localparam int PIN_SCK = 3;
    localparam int PIN_RXD = 4;
    localparam int PIN_TXD = 5;
    // Reset values: all pins general-purpose inputs
    localparam logic [5:0] SEL_RST = 6'h00;
    localparam logic [5:0] GPIO_DIR_RST = 6'h00;
    localparam logic [5:0] GPIO_OUT_RST = 6'h00;
    // Serial port modes
    typedef enum logic {SPS_MODE_SYNC, SPS_MODE_ASYNC} sps_mode_t;
endpackage

// File: design/sps_sync2.sv
// Two-flop synchroniser for a bundle of external levels.
// Assumes inputs are asynchronous to sys_clk.
`timescale 1ns/10ps
module sps_sync2
#(
    parameter int W = 1
)
(
    input wire logic sys_clk,
    input wire logic rstn,
    input wire logic [W-1:0] async_in,
    output logic [W-1:0] sync_out
);
    logic [W-1:0] meta_r;

    // First stage is read only by the second stage
    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            meta_r <= '0;
            sync_out <= '0;
        end
        else
        begin
            meta_r <= async_in;
            sync_out <= meta_r;
        end
    end
endmodule

// File: design/sps_fifo.sv
// Synchronous FIFO with valid/ready on both sides.
// Assumes one clock; width and depth are parameters.
`timescale 1ns/10ps
module sps_fifo
#(
    parameter int WIDTH = 24,
    parameter int DEPTH = 8
)
(
    input wire logic sys_clk,
    input wire logic rstn,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_r [DEPTH];
    logic [AW-1:0] wp_r;
    logic [AW-1:0] rp_r;
    logic [AW:0] cnt_r;
    logic push;
    logic pop;

    // Honest full and empty from the occupancy count
    assign in_ready = (cnt_r != (AW+1)'(DEPTH));
    assign out_valid = (cnt_r != '0);
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;
    assign out_data = mem_r[rp_r];

    // Storage write
    always_ff @(posedge sys_clk)
    begin
        if (push)
            mem_r[wp_r] <= in_data;
    end

    // Pointers and count
    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            wp_r <= '0;
            rp_r <= '0;
            cnt_r <= '0;
        end
        else
        begin
            if (push)
                wp_r <= (wp_r == AW'(DEPTH-1)) ? '0 : wp_r + 1'b1;
            if (pop)
                rp_r <= (rp_r == AW'(DEPTH-1)) ? '0 : rp_r + 1'b1;
            if (push && !pop)
                cnt_r <= cnt_r + 1'b1;
            else if (pop && !push)
                cnt_r <= cnt_r - 1'b1;
        end
    end
endmodule

// File: design/sps_top.sv
// Pin-sharing and shifting logic for a synchronous serial port on six
// shared port lines. Assumes pins reach it as in/out/oe triples and that
// the bit clock from the far side is far slower than sys_clk.
`timescale 1ns/10ps
module sps_top
#(
    parameter int WORD_W = sps_pkg::WORD_W,
    parameter int FIFO_DEPTH = sps_pkg::FIFO_DEPTH,
    parameter int CLK_DIV = 4
)
(
    input wire logic sys_clk,
    input wire logic rstn,
    // Configuration
    input wire logic [5:0] pin_sel,
    input wire logic mode_async,
    input wire logic clk_master,
    input wire logic fsync_master,
    input wire logic [1:0] flag_out,
    input wire logic [1:0] flag_dir,
    input wire logic [5:0] gpio_dir,
    input wire logic [5:0] gpio_out,
    output logic [5:0] gpio_in,
    output logic [1:0] flag_in,
    // Transmit and receive words
    input wire logic tx_valid,
    output logic tx_ready,
    input wire logic [WORD_W-1:0] tx_data,
    output logic rx_valid,
    input wire logic rx_ready,
    output logic [WORD_W-1:0] rx_data,
    output logic rx_overrun,
    // Shared pins: port lines 3..8
    input wire logic flag_clock_pin_a_in,
    output logic flag_clock_pin_a_out,
    output logic flag_clock_pin_a_oe,
    input wire logic flag_framesync_pin_b_in,
    output logic flag_framesync_pin_b_out,
    output logic flag_framesync_pin_b_oe,
    input wire logic framesync_pin_c_in,
    output logic framesync_pin_c_out,
    output logic framesync_pin_c_oe,
    input wire logic bit_clock_pin_in,
    output logic bit_clock_pin_out,
    output logic bit_clock_pin_oe,
    input wire logic receive_data_pin_in,
    output logic receive_data_pin_out,
    output logic receive_data_pin_oe,
    input wire logic transmit_data_pin_in,
    output logic transmit_data_pin_out,
    output logic transmit_data_pin_oe
);
    localparam int CW = sps_pkg::CNT_W;
    logic [5:0] pin_raw;
    logic [5:0] pin_s;
    logic [5:0] sel_r;
    logic [5:0] gdir_r;
    logic [5:0] gout_r;
    logic [5:0] sp_oe;
    logic [5:0] sp_out;
    logic [5:0] pad_out;
    logic [5:0] pad_oe;
    sps_pkg::sps_mode_t mode_r;
    logic [1:0] flag_r;
    logic sck_prev_r;
    logic sck_int_r;
    logic [7:0] div_r;
    logic sck_now;
    logic sck_rise;
    logic sck_fall;
    logic fs_now;
    logic [WORD_W-1:0] rx_sh_r;
    logic [CW-1:0] rx_cnt_r;
    logic rx_act_r;
    logic [WORD_W-1:0] rx_word_r;
    logic rx_push_r;
    logic rx_in_ready;
    logic [WORD_W-1:0] tx_sh_r;
    logic [CW-1:0] tx_cnt_r;
    logic tx_act_r;
    logic fs_out_r;
    logic txd_r;

    // Pins arrive unsynchronised, so every one takes two flops
    assign pin_raw = {transmit_data_pin_in, receive_data_pin_in,
                      bit_clock_pin_in, framesync_pin_c_in,
                      flag_framesync_pin_b_in, flag_clock_pin_a_in};
    sps_sync2 #(.W(sps_pkg::PIN_N)) u_sync
    (
        .sys_clk(sys_clk),
        .rstn(rstn),
        .async_in(pin_raw),
        .sync_out(pin_s)
    );

    // Configuration latched except clk_master, fsync_master and flag_dir; reset leaves all pins as GPIO inputs
    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            sel_r <= sps_pkg::SEL_RST;
            gdir_r <= sps_pkg::GPIO_DIR_RST;
            gout_r <= sps_pkg::GPIO_OUT_RST;
            mode_r <= sps_pkg::SPS_MODE_SYNC;
            flag_r <= 2'h0;
        end
        else
        begin
            sel_r <= pin_sel;
            gdir_r <= gpio_dir;
            gout_r <= gpio_out;
            mode_r <= mode_async ? sps_pkg::SPS_MODE_ASYNC
                                 : sps_pkg::SPS_MODE_SYNC;
            flag_r <= flag_out;
        end
    end

    // Internal bit clock when this end is the clock source
    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            div_r <= 8'h00;
            sck_int_r <= 1'b0;
        end
        else if (div_r == 8'(CLK_DIV - 1))
        begin
            div_r <= 8'h00;
            sck_int_r <= ~sck_int_r;
        end
        else
            div_r <= div_r + 8'h01;
    end

    // Bit clock: internal when clk_master, else from the clock pin, or pin A in async mode
    always_comb
    begin
        if (clk_master)
            sck_now = sck_int_r;
        else if (mode_r == sps_pkg::SPS_MODE_ASYNC)
            sck_now = pin_s[sps_pkg::PIN_A];
        else
            sck_now = pin_s[sps_pkg::PIN_SCK];
        if (fsync_master)
            fs_now = fs_out_r;
        else if (mode_r == sps_pkg::SPS_MODE_ASYNC)
            fs_now = pin_s[sps_pkg::PIN_B];
        else
            fs_now = pin_s[sps_pkg::PIN_C];
    end

    // Edge finder on the already synchronised clock
    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
            sck_prev_r <= 1'b0;
        else
            sck_prev_r <= sck_now;
    end
    assign sck_rise = sck_now && !sck_prev_r;
    assign sck_fall = !sck_now && sck_prev_r;

    // Receive shifter samples on falling bit clock edges, MSB first
    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            rx_sh_r <= '0;
            rx_cnt_r <= '0;
            rx_act_r <= 1'b0;
            rx_word_r <= '0;
            rx_push_r <= 1'b0;
        end
        else
        begin
            rx_push_r <= 1'b0;
            if (sck_fall && sel_r[sps_pkg::PIN_RXD] && (fs_now || rx_act_r))
            begin
                rx_sh_r <= {rx_sh_r[WORD_W-2:0],
                            pin_s[sps_pkg::PIN_RXD]};
                if (rx_cnt_r == CW'(WORD_W - 1))
                begin
                    rx_cnt_r <= '0;
                    rx_act_r <= 1'b0;
                    rx_word_r <= {rx_sh_r[WORD_W-2:0],
                                  pin_s[sps_pkg::PIN_RXD]};
                    rx_push_r <= 1'b1;
                end
                else
                begin
                    rx_cnt_r <= rx_cnt_r + 1'b1;
                    rx_act_r <= 1'b1;
                end
            end
        end
    end

    // Full receive FIFO drops the word and flags it
    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
            rx_overrun <= 1'b0;
        else
            rx_overrun <= rx_push_r && !rx_in_ready;
    end

    sps_fifo #(.WIDTH(WORD_W), .DEPTH(FIFO_DEPTH)) u_rx_fifo
    (
        .sys_clk(sys_clk),
        .rstn(rstn),
        .in_valid(rx_push_r),
        .in_ready(rx_in_ready),
        .in_data(rx_word_r),
        .out_valid(rx_valid),
        .out_ready(rx_ready),
        .out_data(rx_data)
    );

    // Transmit word accepted only when the shifter is idle
    assign tx_ready = !tx_act_r && sck_rise && sel_r[sps_pkg::PIN_TXD];

    // Transmit shifter changes data on rising bit clock edges
    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            tx_sh_r <= '0;
            tx_cnt_r <= '0;
            tx_act_r <= 1'b0;
            fs_out_r <= 1'b0;
            txd_r <= 1'b0;
        end
        else if (sck_rise)
        begin
            fs_out_r <= 1'b0;
            if (tx_valid && tx_ready)
            begin
                txd_r <= tx_data[WORD_W-1];
                tx_sh_r <= {tx_data[WORD_W-2:0], 1'b0};
                tx_cnt_r <= CW'(WORD_W - 1);
                tx_act_r <= 1'b1;
                fs_out_r <= 1'b1;
            end
            else if (tx_act_r)
            begin
                txd_r <= tx_sh_r[WORD_W-1];
                tx_sh_r <= {tx_sh_r[WORD_W-2:0], 1'b0};
                tx_cnt_r <= tx_cnt_r - 1'b1;
                tx_act_r <= (tx_cnt_r != CW'(1));
            end
        end
    end

    // Serial-function drive per pin, by mode
    always_comb
    begin
        sp_out = 6'h00;
        sp_oe = 6'h00;
        if (mode_r == sps_pkg::SPS_MODE_ASYNC)
        begin
            sp_out[sps_pkg::PIN_A] = sck_int_r;
            sp_oe[sps_pkg::PIN_A] = clk_master;
            sp_out[sps_pkg::PIN_B] = fs_out_r;
            sp_oe[sps_pkg::PIN_B] = fsync_master;
            sp_oe[sps_pkg::PIN_C] = 1'b0;
        end
        else
        begin
            sp_out[sps_pkg::PIN_A] = flag_r[0];
            sp_oe[sps_pkg::PIN_A] = flag_dir[0];
            sp_out[sps_pkg::PIN_B] = flag_r[1];
            sp_oe[sps_pkg::PIN_B] = flag_dir[1];
            sp_out[sps_pkg::PIN_C] = fs_out_r;
            sp_oe[sps_pkg::PIN_C] = fsync_master;
        end
        sp_out[sps_pkg::PIN_SCK] = sck_int_r;
        sp_oe[sps_pkg::PIN_SCK] = clk_master &&
            (mode_r == sps_pkg::SPS_MODE_SYNC);
        sp_out[sps_pkg::PIN_TXD] = txd_r;
        sp_oe[sps_pkg::PIN_TXD] = 1'b1;
    end

    // Unselected pins fall back to general-purpose port lines
    assign pad_out = (sel_r & sp_out) | (~sel_r & gout_r);
    assign pad_oe = (sel_r & sp_oe) | (~sel_r & gdir_r);
    assign gpio_in = pin_s;
    assign flag_in = {pin_s[sps_pkg::PIN_B], pin_s[sps_pkg::PIN_A]};

    assign flag_clock_pin_a_out = pad_out[sps_pkg::PIN_A];
    assign flag_clock_pin_a_oe = pad_oe[sps_pkg::PIN_A];
    assign flag_framesync_pin_b_out = pad_out[sps_pkg::PIN_B];
    assign flag_framesync_pin_b_oe = pad_oe[sps_pkg::PIN_B];
    assign framesync_pin_c_out = pad_out[sps_pkg::PIN_C];
    assign framesync_pin_c_oe = pad_oe[sps_pkg::PIN_C];
    assign bit_clock_pin_out = pad_out[sps_pkg::PIN_SCK];
    assign bit_clock_pin_oe = pad_oe[sps_pkg::PIN_SCK];
    assign receive_data_pin_out = pad_out[sps_pkg::PIN_RXD];
    // Receive pin never driven by the serial function
    assign receive_data_pin_oe = pad_oe[sps_pkg::PIN_RXD];
    assign transmit_data_pin_out = pad_out[sps_pkg::PIN_TXD];
    assign transmit_data_pin_oe = pad_oe[sps_pkg::PIN_TXD];
endmodule

// File: verification/sps_top_asserts.sv
// Port-level checks for the serial port pin-sharing block.
// Assumes it is bound to sps_top and sees only that module's ports.
`timescale 1ns/10ps
module sps_top_asserts
#(
    parameter int WORD_W = 24
)
(
    input wire logic sys_clk,
    input wire logic rstn,
    input wire logic [5:0] pin_sel,
    input wire logic mode_async,
    input wire logic clk_master,
    input wire logic [1:0] flag_out,
    input wire logic [1:0] flag_dir,
    input wire logic [5:0] gpio_dir,
    input wire logic tx_valid,
    input wire logic tx_ready,
    input wire logic [WORD_W-1:0] tx_data,
    input wire logic rx_valid,
    input wire logic rx_ready,
    input wire logic [WORD_W-1:0] rx_data,
    input wire logic rx_overrun,
    input wire logic flag_clock_pin_a_out,
    input wire logic flag_clock_pin_a_oe,
    input wire logic flag_framesync_pin_b_out,
    input wire logic flag_framesync_pin_b_oe,
    input wire logic framesync_pin_c_oe,
    input wire logic bit_clock_pin_oe,
    input wire logic receive_data_pin_oe,
    input wire logic transmit_data_pin_out,
    input wire logic transmit_data_pin_oe
);
    // Enables in pin-index order
    wire [5:0] oe = {transmit_data_pin_oe, receive_data_pin_oe,
        bit_clock_pin_oe, framesync_pin_c_oe, flag_framesync_pin_b_oe,
        flag_clock_pin_a_oe};
    wire tx_msb = tx_data[WORD_W-1];
    logic [5:0] sel_q, dir_q;
    logic [1:0] fout_q;
    logic async_q, cm_q, ok_q;
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rstn);
    // Config as latched; ok_q masks the first edge after reset
    always_ff @(posedge sys_clk or negedge rstn)
        if (!rstn)
            ok_q <= 1'b0;
        else
            ok_q <= 1'b1;
    always_ff @(posedge sys_clk)
    begin
        sel_q <= pin_sel;
        dir_q <= gpio_dir;
        fout_q <= flag_out;
        async_q <= mode_async;
        cm_q <= clk_master;
    end
    a_reset_inputs: assert property ($rose(rstn) |-> oe == 6'h00)
        else $error("pin driven at reset release");
    a_gpio_direction: assert property (
        ok_q |-> ((oe ^ dir_q) & ~sel_q) == 6'h00)
        else $error("port line direction wrong");
    a_rx_undriven: assert property (
        ok_q && sel_q[4] |-> !receive_data_pin_oe)
        else $error("receive pin driven");
    a_flag_a_sync: assert property (
        ok_q && sel_q[0] && !async_q |-> flag_clock_pin_a_oe == flag_dir[0]
        && (!flag_dir[0] || flag_clock_pin_a_out == fout_q[0]))
        else $error("pin A not a flag");
    a_flag_b_sync: assert property (
        ok_q && sel_q[1] && !async_q |-> flag_framesync_pin_b_oe == flag_dir[1]
        && (!flag_dir[1] || flag_framesync_pin_b_out == fout_q[1]))
        else $error("pin B not a flag");
    a_async_c_input: assert property (
        ok_q && sel_q[2] && async_q |-> !framesync_pin_c_oe)
        else $error("pin C driven in async mode");
    a_sck_source: assert property (
        ok_q && sel_q[3] && (async_q || !clk_master && !cm_q)
        |-> !bit_clock_pin_oe)
        else $error("bit clock driven by non-source");
    a_tx_msb_first: assert property (
        tx_valid && tx_ready |=> transmit_data_pin_oe
        && transmit_data_pin_out == $past(tx_msb))
        else $error("first transmit bit wrong");
    a_rx_word_hold: assert property (
        rx_valid && !rx_ready |=> rx_valid && $stable(rx_data))
        else $error("receive word not held");
    a_overrun_pulse: assert property (rx_overrun |=> !rx_overrun)
        else $error("overrun longer than one cycle");
endmodule

// File: verification/sps_codec_model.sv
// Behavioural serial peripheral: supplies bit clock, frame sync and data.
// Assumes the bench resolves its outputs against the block's enables.
`timescale 1ns/10ps
module sps_codec_model
(
    input wire logic txd,
    output logic sck,
    output logic fs,
    output logic rxd,
    output logic [23:0] cap
);
    initial
    begin
        sck = 1'b0;
        fs = 1'b0;
        rxd = 1'b0;
        cap = 24'h00_0000;
    end
    // Clock runs only within a frame; data changes on the rising edge
    task automatic frame(input logic [23:0] w);
        int i;
        #30;
        for (i = 23; i >= 0; i--)
        begin
            sck = 1'b1;
            fs = (i == 23);
            rxd = w[i];
            #200;
            sck = 1'b0;
            #100;
            cap = {cap[22:0], txd}; // Mid low half: away from bit changes
            #100;
        end
        fs = 1'b0;
        rxd = ~rxd; // Line inverted after the frame: no stale value
    endtask
endmodule

// File: verification/testbench.sv
// Self-checking bench for the pin-sharing block.
// Assumes the codec model and the bound checker compile beside it.
`timescale 1ns/10ps
module testbench;
    localparam int W = sps_pkg::WORD_W;
    logic sys_clk = 0, rstn = 0, mode_async = 0, clk_master = 0;
    logic fsync_master = 0, tx_valid = 0, rx_ready = 0, use_model = 0;
    logic [1:0] flag_out = 0, flag_dir = 0, flag_in;
    logic [5:0] pin_sel = 0, gpio_dir = 0, gpio_out = 0, gpio_in, ext = 0;
    logic [W-1:0] tx_data = 0, rx_data, cap;
    logic tx_ready, rx_valid, rx_overrun, m_sck, m_fs, m_rxd;
    logic flag_clock_pin_a_out, flag_clock_pin_a_oe;
    logic flag_framesync_pin_b_out, flag_framesync_pin_b_oe;
    logic framesync_pin_c_out, framesync_pin_c_oe;
    logic bit_clock_pin_out, bit_clock_pin_oe;
    logic receive_data_pin_out, receive_data_pin_oe;
    logic transmit_data_pin_out, transmit_data_pin_oe;
    logic [W-1:0] rx_q[$], tx_q[$];
    int num_errors = 0, check_count = 0, ovr_n = 0, k, n;
    wire [5:0] oe = {transmit_data_pin_oe, receive_data_pin_oe,
        bit_clock_pin_oe, framesync_pin_c_oe, flag_framesync_pin_b_oe,
        flag_clock_pin_a_oe};
    wire [5:0] out = {transmit_data_pin_out, receive_data_pin_out,
        bit_clock_pin_out, framesync_pin_c_out, flag_framesync_pin_b_out,
        flag_clock_pin_a_out};
    // Driving party wins, else the outside source
    wire [5:0] lvl = (oe & out) | (~oe & (use_model ?
        {ext[5], m_rxd, m_sck, m_fs, ext[1:0]} : ext));
    wire flag_clock_pin_a_in = lvl[0];
    wire flag_framesync_pin_b_in = lvl[1];
    wire framesync_pin_c_in = lvl[2];
    wire bit_clock_pin_in = lvl[3];
    wire receive_data_pin_in = lvl[4];
    wire transmit_data_pin_in = lvl[5];
    sps_top dut_u (.*);
    sps_codec_model model_u (.txd(lvl[5]), .sck(m_sck), .fs(m_fs),
        .rxd(m_rxd), .cap(cap));
    always #25 sys_clk = ~sys_clk;
    task automatic step(input int c);
        repeat (c) @(posedge sys_clk);
        #1;
    endtask
    task automatic check_bits(input string nm, input logic [5:0] e, g);
        check_count++;
        if (g !== e)
        begin
            num_errors++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic check_word(input string nm, input logic [W-1:0] e, g);
        check_count++;
        if (g !== e)
        begin
            num_errors++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask
    // Level changes of one pin over 32 cycles
    task automatic toggles(input int i, output int t);
        logic p;
        t = 0;
        p = lvl[i];
        repeat (32)
        begin
            step(1);
            t += int'(lvl[i] !== p);
            p = lvl[i];
        end
    endtask
    task automatic complete_run;
        $display("Checks %0d errors %0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    // Words crossing both handshakes; next tx word shortly after a take
    always @(posedge sys_clk)
    begin
        if (rx_valid === 1'b1 && rx_ready === 1'b1)
            rx_q.push_back(rx_data);
        if (rx_overrun === 1'b1)
            ovr_n++;
        if (tx_valid === 1'b1 && tx_ready === 1'b1)
        begin
            tx_q.push_back(tx_data);
            #1 tx_data = {tx_data[W-2:0], ~tx_data[W-1]};
        end
    end
    // Watchdog sized well above the nine-frame stream
    initial
    begin
        #300_000;
        num_errors++;
        complete_run;
    end
    initial
    begin
        step(10);
        rstn = 1;
        step(2);
        check_bits("reset_oe", 6'h00, oe);
        ext = 6'h2D;
        step(5);
        check_bits("gpio_in", 6'h2D, gpio_in);
        gpio_dir = 6'h3F;
        gpio_out = 6'h12;
        step(2);
        check_bits("gpio_out", 6'h12, lvl);
        gpio_dir = 6'h00;
        pin_sel = 6'h3F;
        flag_dir = 2'h3;
        for (k = 0; k < 4; k++)
        begin
            flag_out = k[1:0];
            step(2);
            check_bits("flags", 6'(k), {4'h0, lvl[1:0]});
        end
        flag_dir = 2'h1;
        flag_out = 2'h0;
        ext = 6'h02;
        step(5);
        check_bits("flag_in", 6'h02, {4'h0, flag_in});
        // Frame sync inputs low, or async clocking starts a stray receive
        ext = 6'h00;
        clk_master = 1;
        toggles(3, n);
        check_bits("sck_runs", 6'h01, {5'h00, n >= 6});
        toggles(0, n);
        check_bits("a_quiet", 6'h00, 6'(n));
        mode_async = 1;
        toggles(0, n);
        check_bits("a_clock", 6'h01, {5'h00, n >= 6});
        check_bits("sck_off", 6'h00, {5'h00, oe[3]});
        clk_master = 0;
        step(2);
        check_bits("async_in", 6'h00, oe & 6'h0F);
        mode_async = 0;
        use_model = 1;
        flag_dir = 2'h0;
        tx_data = 24'hA5_C381;
        tx_valid = 1;
        step(2);
        for (k = 0; k < 9; k++)
        begin
            model_u.frame(24'h3C_0F00 + W'(k));
            step(4);
            check_word("tx_word", tx_q[k], cap);
        end
        check_bits("overrun", 6'h01, 6'(ovr_n));
        rx_ready = 1;
        step(20);
        check_bits("rx_count", 6'h08, 6'(rx_q.size()));
        for (k = 0; k < 8; k++)
            check_word("rx_word", 24'h3C_0F00 + W'(k), rx_q[k]);
        // Own frame sync on pin C: one bit period high as a word starts
        clk_master = 1;
        fsync_master = 1;
        toggles(2, n);
        check_bits("fs_pulse", 6'h02, 6'(n));
        mode_async = 1;
        step(2);
        check_bits("b_fs_out", 6'h02, oe & 6'h06);
        rstn = 0;
        step(2);
        check_bits("rerun_oe", 6'h00, oe);
        rstn = 1;
        step(4);
        complete_run;
    end
endmodule
bind sps_top sps_top_asserts #(.WORD_W(WORD_W)) chk_u (.*);
